// ---- design/spm_top.sv ----
// Purpose: in-system serial programming of flash and eeprom arrays
// Assumes: SCK is a clock of its own; CLK runs at 100 MHz
// Notes: arrays are flip-flops and hold no reset value
//
// Operation
// - programming is accepted only while the reset pin is held low
// - program or erase runs only after a valid programming-enable
// - an eeprom byte write erases the byte itself, no chip erase needed
// - chip erase sets every flash and eeprom location to all ones
// - serial input is sampled on the rising clock edge
// - serial output changes on the falling clock edge
// - the second enable byte echoes back during the third byte
// - instructions out of four-byte framing are not acted upon
// - page buffer loads one byte per instruction with six word bits
// - write-page with seven page bits commits the buffer to flash
// - eeprom writes one byte per instruction; programmer waits or polls
// - a read instruction returns the stored content of the location
// - reads in a flash page under programming return all ones
// - enable is byte one 0xAC and byte two 0x53, rest ignored
`timescale 1ns/1ps
module spm_top #(
  parameter int FLASH_WAIT_CYC = spm_pkg::FLASH_WAIT_CYC,
  parameter int EE_WAIT_CYC = spm_pkg::EE_WAIT_CYC,
  parameter int ERASE_WAIT_CYC = spm_pkg::ERASE_WAIT_CYC
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic RESET_N,
  input wire logic SCK,
  input wire logic MOSI,
  output logic MISO,
  output logic MISO_OE,
  output logic PROG_ENABLED,
  output logic BUSY
);
  spm_link_if lnk ();

  logic [1:0] rsync_q;
  logic prog_act_q;
  logic [spm_pkg::SYNC_N-1:0] itg_q;
  logic [spm_pkg::SYNC_N-1:0] htg_q;
  logic iseen_q;
  logic hseen_q;
  logic instr_evt;
  logic hdr_evt;
  logic enabled_q;
  spm_pkg::spm_op_t op_q;
  logic [spm_pkg::WAIT_W-1:0] wait_q;
  logic [spm_pkg::PAGE_W-1:0] page_q;
  logic [spm_pkg::EE_ADDR_W-1:0] ee_addr_q;
  logic [7:0] ee_data_q;
  logic [7:0] resp_q;
  logic [7:0] rd_d;
  logic [15:0] page_buf [spm_pkg::PAGE_WORDS];
  logic [15:0] flash_mem [spm_pkg::FLASH_WORDS];
  logic [7:0] ee_mem [spm_pkg::EE_BYTES];
  logic [7:0] ib1;
  logic [7:0] ib2;
  logic [7:0] ib3;
  logic [7:0] ib4;
  logic cmd_ok;
  logic key_ok;
  logic st_erase;
  logic st_flash;
  logic st_ee;
  logic ld_page;
  logic commit;
  logic commit_flash;
  logic commit_ee;
  logic commit_erase;
  logic rd_flash;
  logic rd_ee;
  logic [spm_pkg::FL_ADDR_W-1:0] fl_rd_addr;
  logic [spm_pkg::EE_ADDR_W-1:0] ee_rd_addr;

  spm_link u_link (
    .sck(SCK),
    .mosi(MOSI),
    .rst_link(RESET_N),
    .miso(MISO),
    .miso_oe(MISO_OE),
    .lnk(lnk.link)
  );

  // ---------------------------------------------------------------
  // crossings into the core clock
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      rsync_q <= 2'h3;
      prog_act_q <= 1'b0;
    end else begin
      rsync_q <= {rsync_q[0], RESET_N};
      prog_act_q <= ~rsync_q[1];
    end
  end

  // one stage beyond the pair brings a reset toggle in on the same edge that prog_act_q drops
  always_ff @(posedge CLK) begin
    if (RST) begin
      itg_q <= '0;
      htg_q <= '0;
      iseen_q <= 1'b0;
      hseen_q <= 1'b0;
    end else begin
      itg_q <= {itg_q[spm_pkg::SYNC_N-2:0], lnk.instr_tgl};
      htg_q <= {htg_q[spm_pkg::SYNC_N-2:0], lnk.hdr_tgl};
      iseen_q <= itg_q[spm_pkg::SYNC_N-1];
      hseen_q <= htg_q[spm_pkg::SYNC_N-1];
    end
  end

  assign instr_evt = prog_act_q && (itg_q[spm_pkg::SYNC_N-1] != iseen_q);
  assign hdr_evt = prog_act_q && (htg_q[spm_pkg::SYNC_N-1] != hseen_q);

  // ---------------------------------------------------------------
  // instruction decode
  // ---------------------------------------------------------------
  assign ib1 = lnk.instr[31:24];
  assign ib2 = lnk.instr[23:16];
  assign ib3 = lnk.instr[15:8];
  assign ib4 = lnk.instr[7:0];
  assign key_ok = instr_evt && ib1 == spm_pkg::OPC_PROG_EN && ib2 == spm_pkg::KEY_ECHO;
  assign cmd_ok = instr_evt && enabled_q && op_q == spm_pkg::OP_IDLE;
  assign st_erase = cmd_ok && ib1 == spm_pkg::OPC_PROG_EN && ib2[7:5] == spm_pkg::ERASE_SEL;
  assign st_flash = cmd_ok && ib1 == spm_pkg::OPC_WR_PAGE;
  assign st_ee = cmd_ok && ib1 == spm_pkg::OPC_WR_EE;
  assign ld_page = cmd_ok && (ib1 == spm_pkg::OPC_LD_LO || ib1 == spm_pkg::OPC_LD_HI);
  assign commit = op_q != spm_pkg::OP_IDLE && wait_q == '0;
  assign commit_flash = commit && op_q == spm_pkg::OP_FLASH;
  assign commit_ee = commit && op_q == spm_pkg::OP_EE;
  assign commit_erase = commit && op_q == spm_pkg::OP_ERASE;

  // ---------------------------------------------------------------
  // enable handshake
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      enabled_q <= 1'b0;
    end else if (!prog_act_q) begin
      enabled_q <= 1'b0;
    end else if (key_ok) begin
      enabled_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // self-timed operations
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      op_q <= spm_pkg::OP_IDLE;
      wait_q <= '0;
      page_q <= '0;
      ee_addr_q <= '0;
      ee_data_q <= 8'h00;
    end else begin
      case (op_q)
        spm_pkg::OP_IDLE: begin
          if (st_erase) begin
            op_q <= spm_pkg::OP_ERASE;
            wait_q <= spm_pkg::WAIT_W'(ERASE_WAIT_CYC - 1);
          end else if (st_flash) begin
            op_q <= spm_pkg::OP_FLASH;
            wait_q <= spm_pkg::WAIT_W'(FLASH_WAIT_CYC - 1);
            page_q <= {ib2[4:0], ib3[7:6]};
          end else if (st_ee) begin
            op_q <= spm_pkg::OP_EE;
            wait_q <= spm_pkg::WAIT_W'(EE_WAIT_CYC - 1);
            ee_addr_q <= {ib2[0], ib3};
            ee_data_q <= ib4;
          end
        end
        spm_pkg::OP_FLASH, spm_pkg::OP_EE, spm_pkg::OP_ERASE: begin
          if (wait_q == '0) begin
            op_q <= spm_pkg::OP_IDLE;
          end else begin
            wait_q <= wait_q - spm_pkg::WAIT_W'(1);
          end
        end
        default: begin
          op_q <= spm_pkg::OP_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // page buffer
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST || commit_flash) begin
      for (int i = 0; i < spm_pkg::PAGE_WORDS; i++) begin
        page_buf[i] <= spm_pkg::ERASED_WORD;
      end
    end else if (ld_page) begin
      if (ib1[3]) begin
        page_buf[ib3[5:0]][15:8] <= ib4;
      end else begin
        page_buf[ib3[5:0]][7:0] <= ib4;
      end
    end
  end

  // ---------------------------------------------------------------
  // arrays
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (commit_erase) begin
      for (int i = 0; i < spm_pkg::FLASH_WORDS; i++) begin
        flash_mem[i] <= spm_pkg::ERASED_WORD;
      end
    end else if (commit_flash) begin
      for (int i = 0; i < spm_pkg::PAGE_WORDS; i++) begin
        flash_mem[{page_q, spm_pkg::WORD_W'(i)}] <= page_buf[i];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (commit_erase) begin
      for (int i = 0; i < spm_pkg::EE_BYTES; i++) begin
        ee_mem[i] <= spm_pkg::ERASED;
      end
    end else if (commit_ee) begin
      ee_mem[ee_addr_q] <= ee_data_q;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  assign rd_flash = lnk.hdr[23:16] == spm_pkg::OPC_RD_FL_LO || lnk.hdr[23:16] == spm_pkg::OPC_RD_FL_HI;
  assign rd_ee = lnk.hdr[23:16] == spm_pkg::OPC_RD_EE;
  assign fl_rd_addr = {lnk.hdr[12:8], lnk.hdr[7:0]};
  assign ee_rd_addr = {lnk.hdr[8], lnk.hdr[7:0]};

  always_comb begin
    rd_d = 8'h00;
    if (rd_flash) begin
      if (op_q == spm_pkg::OP_ERASE ||
          (op_q == spm_pkg::OP_FLASH && fl_rd_addr[12:6] == page_q)) begin
        rd_d = spm_pkg::ERASED;
      end else if (lnk.hdr[19]) begin
        rd_d = flash_mem[fl_rd_addr][15:8];
      end else begin
        rd_d = flash_mem[fl_rd_addr][7:0];
      end
    end else if (rd_ee) begin
      if (op_q == spm_pkg::OP_ERASE || (op_q == spm_pkg::OP_EE && ee_rd_addr == ee_addr_q)) begin
        rd_d = spm_pkg::ERASED;
      end else begin
        rd_d = ee_mem[ee_rd_addr];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      resp_q <= 8'h00;
    end else if (hdr_evt) begin
      resp_q <= rd_d;
    end
  end

  assign lnk.resp = resp_q;

  // ---------------------------------------------------------------
  // status outputs
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      PROG_ENABLED <= 1'b0;
      BUSY <= 1'b0;
    end else begin
      PROG_ENABLED <= enabled_q;
      BUSY <= op_q != spm_pkg::OP_IDLE;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_flash_busy;
    op_q == spm_pkg::OP_FLASH;
  endsequence

  sequence s_poll_page;
    hdr_evt && rd_flash && fl_rd_addr[12:6] == page_q;
  endsequence

  sequence s_idle_ee_read;
    hdr_evt && rd_ee && op_q == spm_pkg::OP_IDLE;
  endsequence

  sequence s_poll_ee_busy;
    op_q == spm_pkg::OP_EE && hdr_evt && rd_ee && ee_rd_addr == ee_addr_q;
  endsequence

  AST_RELEASE_DROPS_ENABLE: assert property (@(posedge CLK) disable iff (RST)
    !prog_act_q |=> !enabled_q)
    else $error("enable held while reset pin released");

  AST_WORK_NEEDS_ENABLE: assert property (@(posedge CLK) disable iff (RST)
    $rose(op_q != spm_pkg::OP_IDLE) |-> $past(enabled_q))
    else $error("operation started without enable");

  AST_ENABLE_BY_KEY: assert property (@(posedge CLK) disable iff (RST)
    $rose(enabled_q) |-> $past(key_ok))
    else $error("enable set without key bytes");

  AST_IGNORED_UNSYNCED: assert property (@(posedge CLK) disable iff (RST)
    instr_evt && !enabled_q && !key_ok |=> !enabled_q && op_q == spm_pkg::OP_IDLE)
    else $error("instruction acted on before enable");

  AST_ERASE_ALL_ONES: assert property (@(posedge CLK) disable iff (RST)
    commit_erase |=> flash_mem[0] == spm_pkg::ERASED_WORD && ee_mem[spm_pkg::EE_BYTES-1] == spm_pkg::ERASED)
    else $error("chip erase left a location not all ones");

  AST_EE_AUTO_ERASE: assert property (@(posedge CLK) disable iff (RST)
    s_poll_ee_busy |=> resp_q == spm_pkg::ERASED)
    else $error("eeprom byte under write not read as erased");

  AST_EE_WRITE_STORES: assert property (@(posedge CLK) disable iff (RST)
    commit_ee |=> ee_mem[$past(ee_addr_q)] == $past(ee_data_q) && op_q == spm_pkg::OP_IDLE)
    else $error("eeprom byte not stored");

  AST_PAGE_LOAD_LOW: assert property (@(posedge CLK) disable iff (RST)
    ld_page && ib1 == spm_pkg::OPC_LD_LO |=> page_buf[$past(ib3[5:0])][7:0] == $past(ib4))
    else $error("page buffer low byte not loaded");

  AST_PAGE_COMMIT: assert property (@(posedge CLK) disable iff (RST)
    commit_flash |=> flash_mem[{$past(page_q), 6'h00}] == $past(page_buf[0]) &&
    page_buf[0] == spm_pkg::ERASED_WORD)
    else $error("page not committed to flash");

  AST_FLASH_POLL_ONES: assert property (@(posedge CLK) disable iff (RST)
    s_flash_busy ##0 s_poll_page |=> resp_q == spm_pkg::ERASED)
    else $error("poll of busy page did not read all ones");

  AST_EE_READ_BACK: assert property (@(posedge CLK) disable iff (RST)
    s_idle_ee_read |=> resp_q == ee_mem[$past(ee_rd_addr)])
    else $error("eeprom read returned wrong byte");
endmodule

// ---- design/spm_pkg.sv ----
// Purpose: shared constants and types of the serial memory programming block
// Assumes: core clock period of 10 ns
// Notes: wait counts are derived from the self-timed durations
package spm_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam real CLK_PERIOD_NS = 10.0;
  localparam real FLASH_WAIT_MS = 4.5;
  localparam real EE_WAIT_MS = 9.0;
  localparam real ERASE_WAIT_MS = 9.0;
  localparam int FLASH_WAIT_CYC = $rtoi(FLASH_WAIT_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam int EE_WAIT_CYC = $rtoi(EE_WAIT_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam int ERASE_WAIT_CYC = $rtoi(ERASE_WAIT_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam int WAIT_W = 20;
  localparam int SYNC_N = 3;
  // ---------------------------------------------------------------
  // array geometry
  // ---------------------------------------------------------------
  localparam int FLASH_WORDS = 8192;
  localparam int PAGE_WORDS = 64;
  localparam int EE_BYTES = 512;
  localparam int FL_ADDR_W = 13;
  localparam int PAGE_W = 7;
  localparam int WORD_W = 6;
  localparam int EE_ADDR_W = 9;
  // ---------------------------------------------------------------
  // instruction encoding
  // ---------------------------------------------------------------
  localparam logic [7:0] OPC_PROG_EN = 8'hAC;
  localparam logic [7:0] KEY_ECHO = 8'h53;
  localparam logic [2:0] ERASE_SEL = 3'h4;
  localparam logic [7:0] OPC_RD_FL_LO = 8'h20;
  localparam logic [7:0] OPC_RD_FL_HI = 8'h28;
  localparam logic [7:0] OPC_LD_LO = 8'h40;
  localparam logic [7:0] OPC_LD_HI = 8'h48;
  localparam logic [7:0] OPC_WR_PAGE = 8'h4C;
  localparam logic [7:0] OPC_RD_EE = 8'hA0;
  localparam logic [7:0] OPC_WR_EE = 8'hC0;
  localparam logic [7:0] ERASED = 8'hFF;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  // ---------------------------------------------------------------
  // bit positions within a four-byte frame
  // ---------------------------------------------------------------
  localparam logic [4:0] BIT_ECHO = 5'h10;
  localparam logic [4:0] BIT_HDR = 5'h17;
  localparam logic [4:0] BIT_RESP = 5'h18;
  localparam logic [4:0] BIT_LAST = 5'h1F;
  typedef enum logic [1:0] {
    OP_IDLE = 2'b00,
    OP_FLASH = 2'b01,
    OP_EE = 2'b10,
    OP_ERASE = 2'b11
  } spm_op_t;
endpackage

// ---- design/spm_link_if.sv ----
// Purpose: carrier between the link-clock shifter and the core
// Assumes: words stay stable from their toggle until the next toggle
// Notes: toggles cross to the core clock through synchronisers
`timescale 1ns/1ps
interface spm_link_if;
  logic [23:0] hdr;
  logic hdr_tgl;
  logic [31:0] instr;
  logic instr_tgl;
  logic [7:0] resp;
  modport link (output hdr, output hdr_tgl, output instr, output instr_tgl, input resp);
  modport core (input hdr, input hdr_tgl, input instr, input instr_tgl, output resp);
endinterface

// ---- design/spm_link.sv ----
// Purpose: serial shifter running on the programmer's clock
// Assumes: rst_link is high whenever the device is not in programming
// Notes: response byte is taken half a clock after the third byte
`timescale 1ns/1ps
module spm_link (
  input wire logic sck,
  input wire logic mosi,
  input wire logic rst_link,
  output logic miso,
  output logic miso_oe,
  spm_link_if.link lnk
);
  logic [4:0] bit_q;
  logic [31:0] shreg_q;
  logic [7:0] out_q;

  // ---------------------------------------------------------------
  // input shifting
  // ---------------------------------------------------------------
  always_ff @(posedge sck or posedge rst_link) begin
    if (rst_link) begin
      bit_q <= 5'h00;
      shreg_q <= 32'h0000_0000;
    end else begin
      bit_q <= bit_q + 5'h01;
      shreg_q <= {shreg_q[30:0], mosi};
    end
  end

  // ---------------------------------------------------------------
  // frame hand-off
  // ---------------------------------------------------------------
  always_ff @(posedge sck or posedge rst_link) begin
    if (rst_link) begin
      lnk.hdr <= 24'h00_0000;
      lnk.hdr_tgl <= 1'b0;
      lnk.instr <= 32'h0000_0000;
      lnk.instr_tgl <= 1'b0;
    end else begin
      if (bit_q == spm_pkg::BIT_HDR) begin
        lnk.hdr <= {shreg_q[22:0], mosi};
        lnk.hdr_tgl <= ~lnk.hdr_tgl;
      end
      if (bit_q == spm_pkg::BIT_LAST) begin
        lnk.instr <= {shreg_q[30:0], mosi};
        lnk.instr_tgl <= ~lnk.instr_tgl;
      end
    end
  end

  // ---------------------------------------------------------------
  // output shifting
  // ---------------------------------------------------------------
  always_ff @(negedge sck or posedge rst_link) begin
    if (rst_link) begin
      out_q <= 8'h00;
      miso_oe <= 1'b0;
    end else begin
      miso_oe <= 1'b1;
      if (bit_q == spm_pkg::BIT_ECHO) begin
        out_q <= shreg_q[7:0];
      end else if (bit_q == spm_pkg::BIT_RESP) begin
        out_q <= lnk.resp;
      end else begin
        out_q <= {out_q[6:0], 1'b0};
      end
    end
  end

  assign miso = out_q[7];
endmodule

// ---- tb/spm_prog_model.sv ----
// Purpose: behavioural in-system programmer on the serial link
// Assumes: half period of 62.5 ns on the serial clock
// Notes: clock stands low between frames, data line toggles when released
`timescale 1ns/1ps
module spm_prog_model (
  output logic sck,
  output logic mosi,
  input wire logic miso
);
  // ---------------------------------------------------------------
  // idle state
  // ---------------------------------------------------------------
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
  end
  // ---------------------------------------------------------------
  // bit and frame transfers
  // ---------------------------------------------------------------
  // each phase is 6.25 core clocks, above the three-clock minimum
  task automatic shift_bit(input logic b, output logic q);
    mosi = b;
    #62.5;
    q = miso; // miso changed on the previous fall
    sck = 1'b1; // device takes mosi on this rise
    #62.5;
    sck = 1'b0;
  endtask
  // msb first, always all four bytes
  task automatic xfer(input logic [31:0] w, output logic [31:0] r);
    logic q;
    for (int i = 31; i >= 0; i--) begin
      shift_bit(w[i], q);
      r[i] = q;
    end
    mosi = ~w[0];
    #250;
  endtask
  // lone byte, used only to break the framing on purpose
  task automatic shift8(input logic [7:0] w);
    logic q;
    for (int i = 7; i >= 0; i--) begin
      shift_bit(w[i], q);
    end
    mosi = ~w[0];
    #250;
  endtask
endmodule

// ---- tb/tb.sv ----
// Purpose: self-checking bench of the serial programming block
// Assumes: short self-timed counts set by parameter
// Notes: arrays are chip-erased before any value is expected from them
`timescale 1ns/1ps
module tb;
  typedef struct {
    logic [31:0] ins;
    logic [7:0] exp;
    logic rd;
    logic wt;
  } spm_row_t;
  logic CLK, RST, RESET_N, SCK, MOSI, MISO, MISO_OE, PROG_ENABLED, BUSY;
  int n_errors = 0;
  int cmp_count = 0;
  logic [31:0] r;
  spm_row_t rows [15];
  // ---------------------------------------------------------------
  // design and programmer
  // ---------------------------------------------------------------
  spm_top #(.FLASH_WAIT_CYC(1000), .EE_WAIT_CYC(1000), .ERASE_WAIT_CYC(200)) i_spm_top (
    .CLK(CLK), .RST(RST), .RESET_N(RESET_N), .SCK(SCK), .MOSI(MOSI), .MISO(MISO),
    .MISO_OE(MISO_OE), .PROG_ENABLED(PROG_ENABLED), .BUSY(BUSY));
  spm_prog_model i_spm_prog_model (.sck(SCK), .mosi(MOSI), .miso(MISO));
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d, comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic clk_wait(input int n);
    repeat (n) @(negedge CLK);
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    while (BUSY !== 1'b0 && k < 3000) begin
      @(negedge CLK);
      k++;
    end
    if (k >= 3000) begin
      n_errors++;
      $display("Error at %0t: busy never dropped", $time);
      finish_test();
    end
  endtask
  task automatic frame(input logic [31:0] w);
    i_spm_prog_model.xfer(w, r);
    clk_wait(10);
  endtask
  initial begin
    #800us;
    n_errors++;
    $display("Error at %0t: run did not end", $time);
    finish_test();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    RST = 1'b1;
    RESET_N = 1'b0;
    rows[0] = '{32'hAC53_0000, 8'h00, 1'b0, 1'b0};
    rows[1] = '{32'hAC80_0000, 8'h00, 1'b0, 1'b1};
    rows[2] = '{32'h2000_1200, 8'hFF, 1'b1, 1'b0};
    rows[3] = '{32'hA001_2300, 8'hFF, 1'b1, 1'b0};
    rows[4] = '{32'hC001_235A, 8'h00, 1'b0, 1'b1};
    rows[5] = '{32'hA001_2300, 8'h5A, 1'b1, 1'b0};
    rows[6] = '{32'hC001_23A5, 8'h00, 1'b0, 1'b1};
    rows[7] = '{32'hA001_2300, 8'hA5, 1'b1, 1'b0};
    rows[8] = '{32'h4000_0512, 8'h00, 1'b0, 1'b0};
    rows[9] = '{32'h4800_0534, 8'h00, 1'b0, 1'b0};
    rows[10] = '{32'h4C00_4000, 8'h00, 1'b0, 1'b1};
    rows[11] = '{32'h2000_4500, 8'h12, 1'b1, 1'b0};
    rows[12] = '{32'h2800_4500, 8'h34, 1'b1, 1'b0};
    rows[13] = '{32'h2800_4600, 8'hFF, 1'b1, 1'b0};
    rows[14] = '{32'hA000_1100, 8'hFF, 1'b1, 1'b0};
    repeat (2) @(negedge CLK);
    // pin pulse clears the link shifter with SCK already low
    RESET_N = 1'b1;
    repeat (4) @(negedge CLK);
    RESET_N = 1'b0;
    repeat (2) @(negedge CLK);
    chk(PROG_ENABLED, 1'b0, "enabled in reset");
    chk(BUSY, 1'b0, "busy in reset");
    RST = 1'b0;
    clk_wait(10);
    foreach (rows[i]) begin
      frame(rows[i].ins);
      chk(r[15:8], rows[i].ins[23:16], "echo");
      if (rows[i].rd) chk(r[7:0], rows[i].exp, "read data");
      if (rows[i].wt) begin
        chk(BUSY, 1'b1, "busy after write");
        wait_idle();
      end
      if (i == 0) chk(PROG_ENABLED, 1'b1, "enable");
      if (i == 0) chk(MISO_OE, 1'b1, "miso driven in session");
    end
    // eeprom polling: location reads all ones until the write lands
    frame(32'hC000_3377);
    frame(32'hA000_3300);
    chk(r[7:0], 8'hFF, "eeprom poll");
    wait_idle();
    frame(32'hA000_3300);
    chk(r[7:0], 8'h77, "eeprom after poll");
    // flash polling on a second page, word 1
    frame(32'h4000_0199);
    frame(32'h4C00_8000);
    frame(32'h2000_8100);
    chk(r[7:0], 8'hFF, "flash poll");
    wait_idle();
    frame(32'h2000_8100);
    chk(r[7:0], 8'h99, "flash after poll");
    // releasing the reset pin ends the session
    RESET_N = 1'b1;
    clk_wait(6);
    chk(PROG_ENABLED, 1'b0, "enable after pin release");
    chk(MISO_OE, 1'b0, "miso released with pin high");
    chk(MISO, 1'b0, "miso low with pin high");
    RESET_N = 1'b0;
    clk_wait(10);
    frame(32'hC000_4466);
    chk(BUSY, 1'b0, "write before enable");
    frame(32'hA000_4400);
    chk(r[7:0], 8'hFF, "location after refused write");
    // a stray byte puts the enable frame out of step
    i_spm_prog_model.shift8(8'h00);
    frame(32'hAC53_0000);
    chk(PROG_ENABLED, 1'b0, "enable out of step");
    RESET_N = 1'b1;
    clk_wait(4);
    RESET_N = 1'b0;
    clk_wait(10);
    frame(32'hAC53_0000);
    chk(r[15:8], 8'h53, "echo on retry");
    chk(PROG_ENABLED, 1'b1, "enable on retry");
    finish_test();
  end
endmodule
